// file: tac_cmd.sv
// transponder command handler: status, authentication, key learning, enhanced mode
`timescale 1ns/1ps
module tac_cmd #(
	parameter int unsigned TURN_CYCLES = tac_pkg::TURN_CYC,
	parameter int unsigned ERR_HALF_CYCLES = tac_pkg::ERR_HALF_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// lf link, bit clock and gate from the demodulator
	input wire logic lf_clk,
	input wire logic lf_rx,
	input wire logic lf_frame,
	output logic lf_tx,
	output logic lf_tx_en,
	// cipher engine
	output logic aes_start,
	output logic [127:0] aes_data,
	output logic aes_mutual,
	input wire logic aes_done,
	input wire logic [127:0] aes_result,
	// nonvolatile store
	output logic nvm_wr,
	output logic [11:0] nvm_addr,
	output logic [127:0] nvm_wdata,
	output logic key_secure,
	input wire logic nvm_done,
	input wire logic enh_flag_nv,
	// supply control
	output logic field_supply_state
);
	typedef struct packed {
		logic [2:0] lclk;
		logic [1:0] rxd;
		logic [2:0] frm;
		tac_pkg::tac_state_type st;
		logic [1:0] bootcnt;
		logic boot;
		logic [7:0] cnt;
		logic [7:0] cmdb;
		logic [135:0] pay;
		logic [143:0] tx_buf;
		logic [7:0] tx_len;
		logic [7:0] tx_cnt;
		logic [31:0] timer;
		logic [3:0] half;
		logic [1:0] copy;
		logic [1:0] copies;
		logic [7:0] status;
		logic [7:0] cfg;
		logic [7:0] chal;
		logic [7:0] resp;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic lf_tx;
		logic lf_tx_en;
		logic aes_start;
		logic [127:0] aes_data;
		logic aes_mutual;
		logic nvm_wr;
		logic [11:0] nvm_addr;
		logic [127:0] nvm_wdata;
		logic key_secure;
		logic field_batt;
	} tac_reg_type;

	tac_reg_type r;
	tac_reg_type n;
	tac_crc_if crc_if();
	logic crc_clr;
	logic crc_en;
	logic crc_din;
	logic lf_rise;
	logic [3:0] cmd;
	logic [3:0] chk;
	logic [3:0] code;
	logic [7:0] exp_len;
	logic known;
	logic tx_bit;

	tac_crc8 #(
		.POLY(tac_pkg::CRC_POLY)
	) u_crc (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.c(crc_if)
	);

	assign crc_if.clr = crc_clr;
	assign crc_if.en = crc_en;
	assign crc_if.din = crc_din;

	// ========================================================
	// next state
	always_comb begin
		n = r;
		crc_clr = 1'b0;
		crc_en = 1'b0;
		crc_din = 1'b0;
		cmd = r.cmdb[7:4];
		chk = r.cmdb[3:0];
		code = tac_pkg::ST_OK;
		exp_len = 8'h00;
		known = 1'b1;
		tx_bit = 1'b0;
		// link pins are foreign, two flops before any use
		n.lclk = {r.lclk[1:0], lf_clk};
		n.rxd = {r.rxd[0], lf_rx};
		n.frm = {r.frm[1:0], lf_frame};
		lf_rise = r.lclk[1] & ~r.lclk[2];
		n.aes_start = 1'b0;
		n.nvm_wr = 1'b0;

		// bus slave: zero wait states, answers always okay
		if (hready) begin
			n.a_wr = hsel & htrans[1] & hwrite;
			n.a_addr = haddr[7:0];
		end
		if (r.a_wr) begin
			unique case (r.a_addr)
				tac_pkg::REG_CFG: n.cfg = hwdata[7:0];
				tac_pkg::REG_CHAL: n.chal = hwdata[7:0];
				tac_pkg::REG_RESP: n.resp = hwdata[7:0];
				default: ;
			endcase
		end
		if (hready & hsel & htrans[1] & ~hwrite) begin
			unique case (haddr[7:0])
				tac_pkg::REG_CFG: n.hrdata = {24'h000000, r.cfg};
				tac_pkg::REG_CHAL: n.hrdata = {24'h000000, r.chal};
				tac_pkg::REG_RESP: n.hrdata = {24'h000000, r.resp};
				tac_pkg::REG_STATUS: n.hrdata = {24'h000000, r.status};
				tac_pkg::REG_ENH: n.hrdata = {30'h00000000, enh_flag_nv, r.field_batt};
				default: n.hrdata = 32'h00000000;
			endcase
		end

		// expected check and payload length per command
		unique case (cmd)
			tac_pkg::CMD_STATUS: known = (chk == tac_pkg::CHK_STATUS);
			tac_pkg::CMD_ENH: known = (chk == tac_pkg::CHK_ENH);
			tac_pkg::CMD_AUTH: begin
				known = (chk == tac_pkg::CHK_AUTH);
				exp_len = r.chal;
			end
			tac_pkg::CMD_KEY1: begin
				known = (chk == tac_pkg::CHK_KEY1);
				exp_len = tac_pkg::KEY_BITS;
			end
			tac_pkg::CMD_KEY2: begin
				known = (chk == tac_pkg::CHK_KEY2);
				exp_len = tac_pkg::KEY_BITS;
			end
			default: known = 1'b0;
		endcase
		// error priority: check, configuration, length, payload check
		if (!known) begin
			code = tac_pkg::ST_CHECK;
		end else if (cmd == tac_pkg::CMD_AUTH && (r.chal > tac_pkg::MAX_PAY_BITS
				|| r.resp > tac_pkg::MAX_PAY_BITS || r.resp == 8'h00)) begin
			code = tac_pkg::ST_CFG;
		end else if (exp_len == 8'h00 ? r.cnt != tac_pkg::CMD_BITS
				: r.cnt != tac_pkg::CMD_BITS + tac_pkg::CHK_BITS + exp_len) begin
			code = tac_pkg::ST_LEN;
		end else if (exp_len != 8'h00 && crc_if.crc != 8'h00) begin
			code = tac_pkg::ST_CRC;
		end

		unique case (r.st)
			// stored flag is caught after release, once the store has settled
			tac_pkg::S_BOOT: begin
				n.bootcnt = r.bootcnt + 2'h1;
				if (r.bootcnt == tac_pkg::BOOT_WAIT) begin
					n.field_batt = enh_flag_nv;
					if (enh_flag_nv) begin
						// clearing the flag grants one battery session only
						n.boot = 1'b1;
						n.nvm_wr = 1'b1;
						n.nvm_addr = tac_pkg::ENH_FLAG_ADDR;
						n.nvm_wdata = {120'h0, tac_pkg::ENH_FLAG_CLR};
						n.copy = 2'h0;
						n.copies = 2'h1;
						n.st = tac_pkg::S_NVW;
					end else begin
						n.st = tac_pkg::S_IDLE;
					end
				end
			end
			tac_pkg::S_IDLE: begin
				if (r.frm[1] & ~r.frm[2]) begin
					n.cnt = 8'h00;
					n.pay = '0; // short challenges must arrive right aligned, no stale bits
					crc_clr = 1'b1;
					n.st = tac_pkg::S_RX;
				end
			end
			// command field first, then payload and its check through the engine
			tac_pkg::S_RX: begin
				if (lf_rise & r.frm[1]) begin
					if (r.cnt < tac_pkg::CMD_BITS) begin
						n.cmdb = {r.cmdb[6:0], r.rxd[1]};
					end else begin
						n.pay = {r.pay[134:0], r.rxd[1]};
						crc_en = 1'b1;
						crc_din = r.rxd[1];
					end
					if (r.cnt != 8'hFF) begin
						n.cnt = r.cnt + 8'h01;
					end
				end
				if (~r.frm[1] & r.frm[2]) begin
					n.st = tac_pkg::S_CHECK;
				end
			end
			tac_pkg::S_CHECK: begin
				// a query reports the previous session before being recorded
				n.tx_buf = {tac_pkg::SYNC_BYTE, r.status, 128'h0};
				n.tx_len = tac_pkg::CMD_BITS + tac_pkg::CMD_BITS;
				n.status = {cmd, code};
				n.timer = 32'h00000000;
				n.half = 4'h0;
				n.copy = 2'h0;
				n.boot = 1'b0;
				if (code != tac_pkg::ST_OK) begin
					n.lf_tx = 1'b0;
					n.st = tac_pkg::S_ERR;
				end else begin
					unique case (cmd)
						tac_pkg::CMD_AUTH: begin
							n.aes_start = 1'b1;
							n.aes_data = r.pay[135:8];
							n.aes_mutual = r.cfg[tac_pkg::CFG_MUTUAL_BIT];
							n.st = tac_pkg::S_AUTH;
						end
						tac_pkg::CMD_KEY1, tac_pkg::CMD_KEY2: begin
							n.nvm_wr = 1'b1;
							n.nvm_addr = (cmd == tac_pkg::CMD_KEY1) ? tac_pkg::KEY1_SLOT
								: tac_pkg::KEY2_SLOT;
							n.nvm_wdata = r.pay[135:8];
							n.key_secure = r.cfg[tac_pkg::CFG_SECURE_BIT];
							n.copies = tac_pkg::KEY_COPIES;
							n.st = tac_pkg::S_NVW;
						end
						tac_pkg::CMD_ENH: begin
							n.nvm_wr = 1'b1;
							n.nvm_addr = tac_pkg::ENH_FLAG_ADDR;
							n.nvm_wdata = {120'h0, tac_pkg::ENH_FLAG_SET};
							n.copies = 2'h1;
							n.st = tac_pkg::S_NVW;
						end
						default: n.st = tac_pkg::S_TURN;
					endcase
				end
			end
			// cipher output is left aligned; only the configured bits go out
			tac_pkg::S_AUTH: begin
				if (aes_done) begin
					n.tx_buf = {tac_pkg::SYNC_BYTE, aes_result, 8'h00};
					n.tx_len = tac_pkg::CMD_BITS + r.resp;
					n.st = tac_pkg::S_TURN;
				end
			end
			tac_pkg::S_NVW: begin
				if (nvm_done) begin
					if (r.copy + 2'h1 < r.copies) begin
						n.copy = r.copy + 2'h1;
						n.nvm_addr = r.nvm_addr + tac_pkg::KEY_COPY_STRIDE;
						n.nvm_wr = 1'b1;
					end else if (r.boot) begin
						n.st = tac_pkg::S_IDLE;
					end else begin
						// key and flag commands answer with the fresh status
						n.tx_buf = {tac_pkg::SYNC_BYTE, r.status, 128'h0};
						n.st = tac_pkg::S_TURN;
					end
				end
			end
			tac_pkg::S_TURN: begin
				n.timer = r.timer + 32'h00000001;
				if (r.timer == TURN_CYCLES - 1) begin
					n.tx_cnt = 8'h00;
					crc_clr = 1'b1;
					n.st = tac_pkg::S_TX;
				end
			end
			// sync byte is not covered by the check; check bits follow payload
			tac_pkg::S_TX: begin
				if (lf_rise) begin
					if (r.tx_cnt == r.tx_len + tac_pkg::CHK_BITS) begin
						n.lf_tx_en = 1'b0;
						n.lf_tx = 1'b0;
						n.st = tac_pkg::S_IDLE;
					end else begin
						if (r.tx_cnt == r.tx_len) begin
							tx_bit = crc_if.crc[7];
							n.tx_buf = {crc_if.crc[6:0], 137'h0};
						end else begin
							tx_bit = r.tx_buf[143];
							n.tx_buf = {r.tx_buf[142:0], 1'b0};
						end
						if (r.tx_cnt >= tac_pkg::CMD_BITS && r.tx_cnt < r.tx_len) begin
							crc_en = 1'b1;
							crc_din = tx_bit;
						end
						n.lf_tx = tx_bit;
						n.lf_tx_en = 1'b1;
						n.tx_cnt = r.tx_cnt + 8'h01;
					end
				end
			end
			// failure wave runs on the local clock, no lf edges needed
			tac_pkg::S_ERR: begin
				n.lf_tx_en = 1'b1;
				n.timer = r.timer + 32'h00000001;
				if (r.timer == ERR_HALF_CYCLES - 1) begin
					n.timer = 32'h00000000;
					n.lf_tx = ~r.lf_tx;
					n.half = r.half + 4'h1;
					if (r.half == tac_pkg::ERR_HALVES - 4'h1) begin
						n.lf_tx_en = 1'b0;
						n.lf_tx = 1'b0;
						n.st = tac_pkg::S_IDLE;
					end
				end
			end
		endcase
	end

	// ========================================================
	// state register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
			r.st <= tac_pkg::S_BOOT;
			r.cfg <= tac_pkg::RST_CFG;
			r.chal <= tac_pkg::RST_CHAL;
			r.resp <= tac_pkg::RST_RESP;
			r.hreadyout <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// ========================================================
	// outputs, all straight from the state register
	assign hreadyout = r.hreadyout;
	assign hresp = r.hresp;
	assign hrdata = r.hrdata;
	assign lf_tx = r.lf_tx;
	assign lf_tx_en = r.lf_tx_en;
	assign aes_start = r.aes_start;
	assign aes_data = r.aes_data;
	assign aes_mutual = r.aes_mutual;
	assign nvm_wr = r.nvm_wr;
	assign nvm_addr = r.nvm_addr;
	assign nvm_wdata = r.nvm_wdata;
	assign key_secure = r.key_secure;
	assign field_supply_state = r.field_batt;
endmodule

// file: tac_cmd_props.sv
// concurrent checks on the command handler's ports
`timescale 1ns/1ps
module tac_cmd_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// bus answer
	input wire logic hreadyout,
	input wire logic hresp,
	// cipher and store
	input wire logic aes_start,
	input wire logic nvm_wr,
	input wire logic [11:0] nvm_addr,
	input wire logic [127:0] nvm_wdata,
	input wire logic enh_flag_nv,
	input wire logic field_supply_state,
	// link
	input wire logic lf_frame,
	input wire logic lf_tx_en
);
	// ======
	// single domain, so clock and reset are stated once
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// bus slave is zero wait and always okay
	ready_high_a: assert property (hreadyout) else $error("bus stalled");
	resp_okay_a: assert property (!hresp) else $error("bus error response");
	// strobes are single pulses
	cipher_pulse_a: assert property (aes_start |=> !aes_start)
		else $error("cipher strobe long");
	store_pulse_a: assert property (nvm_wr |=> !nvm_wr)
		else $error("store strobe long");
	// power-on decision follows the stored flag, granted once
	boot_supply_a: assert property ($rose(rst_n) && enh_flag_nv
		|-> ##[1:6] field_supply_state) else $error("battery session not granted");
	boot_clear_a: assert property ($rose(rst_n) && enh_flag_nv |-> ##[4:12] (nvm_wr &&
		nvm_addr == tac_pkg::ENH_FLAG_ADDR && nvm_wdata[7:0] == tac_pkg::ENH_FLAG_CLR))
		else $error("flag not cleared");
	boot_mains_a: assert property ($rose(rst_n) && !enh_flag_nv
		|=> !field_supply_state [*6]) else $error("battery without flag");
	// no answer while a request is on the air or the store is busy
	rx_quiet_a: assert property (lf_frame |-> !lf_tx_en) else $error("talks over request");
	store_wait_a: assert property (nvm_wr |-> !lf_tx_en) else $error("answer before store");
endmodule
bind tac_cmd tac_cmd_chk u_tac_cmd_chk (.ref_clk, .rst_n, .hreadyout, .hresp, .aes_start,
	.nvm_wr, .nvm_addr, .nvm_wdata, .enh_flag_nv, .field_supply_state, .lf_frame, .lf_tx_en);

// file: tac_cmd_tb.sv
// self-checking bench for the transponder command handler
`timescale 1ns/1ps
module tac_cmd_tb;
	// ======
	// signals and bench state
	localparam logic [127:0] PAT = 128'hC3A5_5A3C_0F1E_2D4B_9687_7869_E1D2_B4A5;
	localparam logic [127:0] RES = 128'h1357_9BDF_2468_ACE0_F0E1_D2C3_B4A5_9687;
	logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, lf_clk, lf_rx, lf_frame, lf_tx, lf_tx_en;
	logic aes_start, aes_mutual, nvm_wr, key_secure, sm;
	// stand-in outputs start defined; the stored flag survives every reset
	logic aes_done = 1'b0;
	logic nvm_done = 1'b0;
	logic enh_flag_nv = 1'b0;
	logic field_supply_state;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [127:0] aes_data, aes_result, nvm_wdata, seen;
	logic [11:0] nvm_addr;
	logic [11:0] wa[$];
	logic [127:0] wd[$];
	int failures, checks;
	// short turnaround and error wave keep the run brief
	tac_cmd #(.TURN_CYCLES(20), .ERR_HALF_CYCLES(10)) u_tac_cmd (.ref_clk, .rst_n, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .lf_clk, .lf_rx, .lf_frame, .lf_tx, .lf_tx_en, .aes_start, .aes_data,
		.aes_mutual, .aes_done, .aes_result, .nvm_wr, .nvm_addr, .nvm_wdata, .key_secure,
		.nvm_done, .enh_flag_nv, .field_supply_state);
	tac_reader u_tac_reader (.lf_clk, .lf_rx, .lf_frame, .lf_tx, .lf_tx_en);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// cipher and store stand-ins; the store keeps the enhanced flag
	always @(posedge ref_clk) begin
		aes_done <= aes_start;
		nvm_done <= nvm_wr;
		if (aes_start) begin
			seen <= aes_data;
			sm <= aes_mutual;
		end
		if (nvm_wr) begin
			wa.push_back(nvm_addr);
			wd.push_back(nvm_wdata);
			if (nvm_addr == tac_pkg::ENH_FLAG_ADDR)
				enh_flag_nv <= nvm_wdata[7:0] == tac_pkg::ENH_FLAG_SET;
		end
	end
	// ======
	// shared helpers
	task automatic chk(input logic [255:0] got, input logic [255:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic boot;
		rst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (30) @(posedge ref_clk);
	endtask
	// single ahb transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (!hreadyout);
		q = hrdata;
	endtask
	function automatic logic [7:0] crc8(input logic [127:0] p, input int n);
		logic [7:0] c = 8'h00;
		for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// request of n payload bits, answer of m payload bits
	task automatic txn(input logic [7:0] c, input logic [127:0] p, input int n,
		input logic [127:0] r, input int m);
		logic [255:0] b;
		int k;
		b = n ? ((256'(c) << n | 256'(p)) << 8) | 256'(crc8(p, n)) : 256'(c);
		u_tac_reader.send(b, n ? n + 16 : 8);
		u_tac_reader.recv(b, k);
		chk(k, m + 16);
		chk(b, ((256'hFE << m | 256'(r)) << 8) | 256'(crc8(r, m)));
		repeat (20) @(posedge ref_clk);
	endtask
	// faulty request: expect the wave, then the cause in status
	task automatic err(input logic [255:0] b, input int n, input logic [7:0] s);
		int t;
		u_tac_reader.send(b, n);
		for (t = 0; !lf_tx_en && t < 1000; t++) @(posedge ref_clk);
		t = 0;
		while (lf_tx_en) begin
			@(posedge ref_clk);
			t++;
		end
		chk(t > 75 && t < 85, 1);
		repeat (20) @(posedge ref_clk);
		txn(8'h26, 0, 0, 128'(s), 8);
	endtask
	// ======
	// scenarios
	task automatic t_regs;
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
		logic [7:0] v[6] = '{8'h00, 8'h80, 8'h50, 8'h00, 8'h00, 8'h00};
		foreach (a[i]) begin
			bus(1'b0, a[i], 32'h0);
			chk(q, v[i]);
		end
		bus(1'b1, 8'h0C, 32'hFF);
		bus(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h0);
		$display("register test done");
	endtask
	task automatic t_status;
		txn(8'h26, 0, 0, 128'h00, 8);
		txn(8'h26, 0, 0, 128'h20, 8);
		$display("status test done");
	endtask
	task automatic t_auth;
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, 8'h00, m ? 32'h04 : 32'h00);
			bus(1'b1, 8'h04, m ? 32'h68 : 32'h80);
			bus(1'b1, 8'h08, m ? 32'h38 : 32'h50);
			txn(8'h13, PAT >> (m ? 24 : 0), m ? 104 : 128, RES >> (m ? 72 : 48), m ? 56 : 80);
			chk(seen, PAT >> (m ? 24 : 0));
			chk(sm, m);
		end
		$display("authentication test done");
	endtask
	task automatic t_keys;
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, 8'h00, k ? 32'h00 : 32'h40);
			wa.delete();
			wd.delete();
			txn(k ? 8'h8B : 8'h79, ~PAT, 128, k ? 128'h80 : 128'h70, 8);
			chk(wa.size(), 3);
			foreach (wa[j]) begin
				chk(wa[j], (k ? 12'h780 : 12'h7C0) + 12'h010 * j);
				chk(wd[j], {128'h0, ~PAT});
			end
			chk(key_secure, !k);
		end
		$display("key learning test done");
	endtask
	task automatic t_err;
		logic [255:0] b;
		err(256'h27, 8, 8'h21);
		err(256'hE1, 8, 8'hE1);
		err(256'h26AA, 16, 8'h22);
		// check byte inverted on purpose, kept to eight bits
		b = ((256'h13 << 104 | (PAT >> 24)) << 8) | {248'h0, ~crc8(PAT >> 24, 104)};
		err(b, 120, 8'h13);
		// challenge length beyond the cipher block is a configuration fault
		bus(1'b1, 8'h04, 32'h90);
		err(256'h13, 8, 8'h14);
		$display("error test done");
	endtask
	task automatic t_enh;
		wa.delete();
		wd.delete();
		txn(8'h35, 0, 0, 128'h30, 8);
		chk(wa[0], tac_pkg::ENH_FLAG_ADDR);
		chk(wd[0][7:0], tac_pkg::ENH_FLAG_SET);
		boot();
		chk(field_supply_state, 1'b1);
		bus(1'b0, 8'h10, 32'h0);
		chk(q, 32'h1);
		boot();
		chk(field_supply_state, 1'b0);
		$display("enhanced mode test done");
	endtask
	// ======
	// main sequence and watchdog
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		aes_result = RES;
		boot();
		t_regs();
		t_status();
		t_auth();
		t_keys();
		t_err();
		t_enh();
		final_report();
	end
	initial begin
		#800000;
		failures++;
		final_report();
	end
endmodule

// file: tac_crc8.sv
// bit-serial 8-bit check engine shared by receive and transmit
`timescale 1ns/1ps
module tac_crc8 #(
	parameter logic [7:0] POLY = tac_pkg::CRC_POLY
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// engine side of the bundle
	tac_crc_if.eng c
);
	typedef struct packed {
		logic [7:0] crc;
	} tac_crc_state_type;

	tac_crc_state_type r;
	tac_crc_state_type n;

	// ========================================================
	// msb-first shift, zero preset so a trailing check gives zero
	always_comb begin
		n = r;
		if (c.clr) begin
			n.crc = 8'h00;
		end else if (c.en) begin
			n.crc = {r.crc[6:0], 1'b0} ^ ((r.crc[7] ^ c.din) ? POLY : 8'h00);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign c.crc = r.crc;
endmodule

// file: tac_crc_if.sv
// bundle between the handler and its serial check engine
`timescale 1ns/1ps
interface tac_crc_if;
	logic clr;
	logic en;
	logic din;
	logic [7:0] crc;
	modport eng(input clr, input en, input din, output crc);
	modport user(output clr, output en, output din, input crc);
endinterface

// file: tac_pkg.sv
// constants, types and timing for the transponder command handler
//
// Contract
// - status query 0010/0110 returns status byte
// - status: command echo high, code low
// - status kept in ram, refreshed each session
// - 0001/0011 starts challenge-response authentication
// - challenge and response lengths from configuration
// - config bit 2 picks one-way or mutual
// - response is truncated block cipher output
// - response recommended 56 or 80 bits
// - 0111/1001 key stored at 0x7C0, three copies
// - config bit 6 marks key as encrypted
// - 1000/1011 key stored at 0x780, three copies
// - key learning answers status byte plus check
// - 0011/0101 sets nonvolatile enhanced flag
// - power-on inspects flag, sets field switch
// - battery session granted once per command
// - request opens with code and 4-bit check
// - payload always followed by 8-bit check
// - response starts with sync byte 0xFE
// - failure sends 1kHz wave, records cause
package tac_pkg;

	// ========================================================
	// command codes and their fixed checks
	localparam logic [3:0] CMD_AUTH = 4'h1;
	localparam logic [3:0] CHK_AUTH = 4'h3;
	localparam logic [3:0] CMD_STATUS = 4'h2;
	localparam logic [3:0] CHK_STATUS = 4'h6;
	localparam logic [3:0] CMD_ENH = 4'h3;
	localparam logic [3:0] CHK_ENH = 4'h5;
	localparam logic [3:0] CMD_KEY1 = 4'h7;
	localparam logic [3:0] CHK_KEY1 = 4'h9;
	localparam logic [3:0] CMD_KEY2 = 4'h8;
	localparam logic [3:0] CHK_KEY2 = 4'hB;

	// ========================================================
	// status codes in the low nibble
	localparam logic [3:0] ST_OK = 4'h0;
	localparam logic [3:0] ST_CHECK = 4'h1;
	localparam logic [3:0] ST_LEN = 4'h2;
	localparam logic [3:0] ST_CRC = 4'h3;
	localparam logic [3:0] ST_CFG = 4'h4;

	// ========================================================
	// configuration bytes, fields and key slots
	localparam logic [11:0] NV_CFG_AUTH = 12'h811;
	localparam logic [11:0] NV_CHAL_LEN = 12'h815;
	localparam logic [11:0] NV_RESP_LEN = 12'h816;
	localparam int CFG_MUTUAL_BIT = 2;
	localparam int CFG_SECURE_BIT = 6;
	localparam logic [11:0] KEY1_SLOT = 12'h7C0;
	localparam logic [11:0] KEY2_SLOT = 12'h780;
	localparam logic [11:0] KEY_COPY_STRIDE = 12'h010;
	localparam logic [11:0] ENH_FLAG_ADDR = 12'h827;
	localparam logic [7:0] ENH_FLAG_SET = 8'hA5;
	localparam logic [7:0] ENH_FLAG_CLR = 8'h00;
	localparam logic [1:0] KEY_COPIES = 2'h3;

	// ========================================================
	// frame layout
	localparam logic [7:0] SYNC_BYTE = 8'hFE;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CMD_BITS = 8'h08;
	localparam logic [7:0] CHK_BITS = 8'h08;
	localparam logic [7:0] KEY_BITS = 8'h80;
	localparam logic [7:0] MAX_PAY_BITS = 8'h80;

	// ========================================================
	// register map and reset values
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_CHAL = 8'h04;
	localparam logic [7:0] REG_RESP = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_ENH = 8'h10;
	localparam logic [7:0] RST_CFG = 8'h00;
	localparam logic [7:0] RST_CHAL = 8'h80;
	localparam logic [7:0] RST_RESP = 8'h50;
	localparam logic [1:0] BOOT_WAIT = 2'h3;

	// ========================================================
	// timing
	localparam int CLK_NS = 10;
	localparam int TURN_NS = 2000000;
	localparam int TURN_CYC = TURN_NS / CLK_NS;
	localparam int ERR_HZ = 1000;
	localparam int ERR_HALF_NS = 1000000000 / (2 * ERR_HZ);
	localparam int ERR_HALF_CYC = ERR_HALF_NS / CLK_NS;
	localparam logic [3:0] ERR_HALVES = 4'h8;

	// ========================================================
	// handler states
	typedef enum logic [8:0] {
		S_BOOT = 9'h001,
		S_IDLE = 9'h002,
		S_RX = 9'h004,
		S_CHECK = 9'h008,
		S_AUTH = 9'h010,
		S_NVW = 9'h020,
		S_TURN = 9'h040,
		S_TX = 9'h080,
		S_ERR = 9'h100
	} tac_state_type;

endpackage

// file: tac_reader.sv
// base station model: sends requests and collects answers on the lf link
`timescale 1ns/1ps
module tac_reader (
	// link pins
	output logic lf_clk,
	output logic lf_rx,
	output logic lf_frame,
	input wire logic lf_tx,
	input wire logic lf_tx_en
);
	// ======
	// carrier-derived bit clock runs free, 80 ns
	initial begin
		lf_clk = 1'b0;
		lf_rx = 1'b0;
		lf_frame = 1'b0;
		forever #40 lf_clk = ~lf_clk;
	end
	// bits change mid-bit so they are settled at the rising edge
	task automatic send(input logic [255:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge lf_clk);
			lf_frame <= 1'b1;
			lf_rx <= b[i];
		end
		@(negedge lf_clk);
		lf_frame <= 1'b0;
		lf_rx <= ~lf_rx; // released line must not keep the last bit
	endtask
	// each answer bit stands until the next rising edge, so sample there
	task automatic recv(output logic [255:0] b, output int n);
		int w;
		b = '0;
		n = 0;
		w = 0;
		while (!lf_tx_en && w < 5000) begin
			@(posedge lf_clk);
			w++;
		end
		while (lf_tx_en && n < 256) begin
			b = {b[254:0], lf_tx};
			n++;
			@(posedge lf_clk);
		end
	endtask
endmodule
